// [include/exc_pkg.sv]
/*
  constants, types and helpers shared by the critical and machine check
  entry block and its line fill tracker helper module.
  assumes a 32-bit core, byte-addressed register map on an axi4-lite slave.
*/
`default_nettype none

package exc_pkg;

  // register map, byte offsets
  localparam logic [7:0] OFS_MST = 8'h00;
  localparam logic [7:0] OFS_CSPC = 8'h04;
  localparam logic [7:0] OFS_CSST = 8'h08;
  localparam logic [7:0] OFS_VPFX = 8'h0c;
  localparam logic [7:0] OFS_SYND = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // machine state bit positions
  localparam int MST_SLEEP = 18;
  localparam int MST_CRIT = 17;
  localparam int MST_EXT = 15;
  localparam int MST_USER = 14;
  localparam int MST_MCE = 12;
  localparam int MST_WDOG = 10;
  localparam int MST_DBG = 9;
  localparam int MST_IXL = 5;
  localparam int MST_DXL = 4;

  // bits cleared on critical entry; machine check also clears the enable
  localparam logic [31:0] CRIT_CLR = (32'h1 << MST_SLEEP) | (32'h1 << MST_CRIT) |
    (32'h1 << MST_EXT) | (32'h1 << MST_USER) | (32'h1 << MST_WDOG) |
    (32'h1 << MST_DBG) | (32'h1 << MST_IXL) | (32'h1 << MST_DXL);
  localparam logic [31:0] MC_CLR = CRIT_CLR | (32'h1 << MST_MCE);

  // reset values and writable masks
  localparam logic [31:0] MST_RESET = 32'h0000_0000;
  localparam logic [31:0] VPFX_RESET = 32'h0000_0000;
  localparam logic [31:0] VPFX_MASK = 32'hffff_0000;
  localparam logic [31:0] SYND_MASK = 32'h0001_0371;
  localparam int SYND_FETCH_FAULT = 0;

  // vector offsets in the low half of the program counter
  localparam logic [15:0] CRIT_VEC_OFS = 16'h0100;
  localparam logic [15:0] MC_VEC_OFS = 16'h0200;
  localparam logic [15:0] WDOG_VEC_OFS = 16'h1020;

  // last entry cause, status bits 3:0
  localparam logic [3:0] CAUSE_IMC = 4'h1;
  localparam logic [3:0] CAUSE_DMC = 4'h2;
  localparam logic [3:0] CAUSE_CRIT = 4'h4;
  localparam logic [3:0] CAUSE_WDOG = 4'h8;

  localparam int FILL_WORDS = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

  function automatic logic [31:0] vec_addr(input logic [31:0] pfx, input logic [15:0] ofs);
    vec_addr = {pfx[31:16], ofs};
  endfunction : vec_addr

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction : merge

endpackage : exc_pkg

`default_nettype wire

// [verilog/line_fill_tracker.sv]
/*
  follows one instruction cache line fill word by word and decides at the
  end whether the line may be validated or must be invalidated.
  assumes fill_start precedes the words and one word arrives per pulse.
*/
`default_nettype none

module line_fill_tracker #(
  parameter int WORDS = exc_pkg::FILL_WORDS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // fill progress
  input wire logic fill_start_in,
  input wire logic fill_word_in,
  input wire logic fill_err_in,
  // line verdict, one-cycle pulses
  output logic line_validate_out,
  output logic line_invalidate_out
);

  localparam int CW = $clog2(WORDS + 1);
  localparam logic [CW-1:0] LAST = CW'(WORDS - 1);

  typedef struct packed {
    logic active;
    logic [CW-1:0] cnt;
    logic err;
    logic validate;
    logic invalidate;
  } fill_state_t;

  fill_state_t cur_ff;
  fill_state_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.validate = 1'b0;
    nxt_cur.invalidate = 1'b0;
    if (fill_start_in) begin
      nxt_cur.active = 1'b1;
      nxt_cur.cnt = '0;
      nxt_cur.err = 1'b0;
    end else if (cur_ff.active && fill_word_in) begin
      // a bad word poisons the whole line
      if (cur_ff.cnt == LAST) begin
        nxt_cur.active = 1'b0;
        nxt_cur.validate = !(cur_ff.err || fill_err_in);
        nxt_cur.invalidate = cur_ff.err || fill_err_in;
      end else begin
        nxt_cur.cnt = cur_ff.cnt + CW'(1);
        nxt_cur.err = cur_ff.err || fill_err_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign line_validate_out = cur_ff.validate;
  assign line_invalidate_out = cur_ff.invalidate;

endmodule : line_fill_tracker

`default_nettype wire

// [verilog/entry_select.sv]
/*
  decides which exception entry, if any, is taken this cycle.
  assumes the caller registers the outcome; purely combinational.
*/
`default_nettype none

module entry_select (
  // enables from machine state
  input wire logic mce_in,
  input wire logic crit_allow_in,
  // requests
  input wire logic fetch_fault_in,
  input wire logic data_err_in,
  input wire logic crit_irq_in,
  input wire logic wdog_in,
  input wire logic precise_pending_in,
  // one-hot decision
  output logic take_imc_out,
  output logic take_dmc_out,
  output logic take_crit_out,
  output logic take_wdog_out
);

  logic mc_any;
  logic async_ok;

  always_comb begin
    // flag alone never vectors; only a fresh fault while enabled
    take_imc_out = fetch_fault_in && mce_in;
    take_dmc_out = data_err_in && mce_in && !take_imc_out;
    mc_any = take_imc_out || take_dmc_out;
    // precise work outstanding holds the asynchronous classes back
    async_ok = crit_allow_in && !precise_pending_in && !mc_any;
    take_crit_out = crit_irq_in && async_ok;
    take_wdog_out = wdog_in && async_ok && !crit_irq_in;
  end

endmodule : entry_select

`default_nettype wire

// [verilog/crit_mc_entry.sv]
/*
  critical input and machine check entry for the core: save registers,
  machine state update, vectoring, syndrome flag, critical return, and an
  axi4-lite slave that exposes the registers to software.
  assumes core inputs are synchronous to clk_in and that the core applies
  pc_load_out on the cycle after the event it reported.
*/
// Local design decisions: register access over AXI4-Lite and the address map.
`default_nettype none

// Contract
// - critical input taken only while critical_allow set
// - critical_allow also gates watchdog, own vector
// - take critical immediately, save next pc; code holds it back while precise_pending_in is set
// - copy machine state into crit_save_state simultaneously
// - critical entry clears bits except machine_check_enable
// - critical vector is prefix high half, 0x0100
// - return restores pc and machine state
// - fetch fault raised only at attempted execution
// - data bus error raises data machine check
// - instruction machine check saves faulting address
// - data check saves next pc; state saved
// - machine check entry clears all listed bits
// - machine check vector is prefix, 0x0200
// - enabled fetch fault vectors and sets flag
// - only fetch bus error causes instruction check
// - errored eight-word fill line is invalidated
// - flag set even with checks disabled
// - re-enabling does not fire on old flag
// - taken fetch check writes syndrome to one
// - fetch_fault_flag is syndrome bit zero
module crit_mc_entry #(
  parameter int FILL_WORDS = exc_pkg::FILL_WORDS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // interrupt sources
  input wire logic crit_irq_in,
  input wire logic wdog_timeout_in,
  input wire logic precise_pending_in,
  // core pipeline
  input wire logic [31:0] next_pc_in,
  input wire logic exec_valid_in,
  input wire logic [31:0] exec_pc_in,
  input wire logic exec_fetch_err_in,
  input wire logic data_bus_err_in,
  input wire logic crit_return_in,
  // instruction cache line fill
  input wire logic fill_start_in,
  input wire logic fill_word_in,
  input wire logic fill_err_in,
  // redirect and state to the core
  output logic pc_load_out,
  output logic [31:0] pc_target_out,
  output logic [31:0] mst_out,
  output logic line_validate_out,
  output logic line_invalidate_out,
  // axi4-lite write
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  // axi4-lite read
  input wire logic [7:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in
);

  typedef struct packed {
    logic [31:0] mst;
    logic [31:0] cspc;
    logic [31:0] csst;
    logic [31:0] vpfx;
    logic [31:0] synd;
    logic [3:0] cause;
    logic [7:0] inval_cnt;
    logic pc_load;
    logic [31:0] pc_target;
    exc_pkg::wr_state_t wr_state;
    logic aw_rdy;
    logic w_rdy;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    exc_pkg::rd_state_t rd_state;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } entry_state_t;

  entry_state_t cur_ff;
  entry_state_t nxt_cur;

  logic take_imc;
  logic take_dmc;
  logic take_crit;
  logic take_wdog;
  logic fetch_fault;
  logic inval_pulse;

  // only a bus-error tag on an instruction reaching execution counts;
  // speculative fetches that are never executed stay silent
  assign fetch_fault = exec_valid_in && exec_fetch_err_in;

  entry_select u_select (
    .mce_in(cur_ff.mst[exc_pkg::MST_MCE]),
    .crit_allow_in(cur_ff.mst[exc_pkg::MST_CRIT]),
    .fetch_fault_in(fetch_fault),
    .data_err_in(data_bus_err_in),
    .crit_irq_in(crit_irq_in),
    .wdog_in(wdog_timeout_in),
    .precise_pending_in(precise_pending_in),
    .take_imc_out(take_imc),
    .take_dmc_out(take_dmc),
    .take_crit_out(take_crit),
    .take_wdog_out(take_wdog)
  );

  line_fill_tracker #(
    .WORDS(FILL_WORDS)
  ) u_fill (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .fill_start_in(fill_start_in),
    .fill_word_in(fill_word_in),
    .fill_err_in(fill_err_in),
    .line_validate_out(line_validate_out),
    .line_invalidate_out(inval_pulse)
  );

  assign line_invalidate_out = inval_pulse;

  function automatic logic [31:0] read_reg(input entry_state_t s, input logic [7:0] a);
    case (a)
      exc_pkg::OFS_MST: read_reg = s.mst;
      exc_pkg::OFS_CSPC: read_reg = s.cspc;
      exc_pkg::OFS_CSST: read_reg = s.csst;
      exc_pkg::OFS_VPFX: read_reg = s.vpfx;
      exc_pkg::OFS_SYND: read_reg = s.synd;
      exc_pkg::OFS_STAT: read_reg = {16'h0000, s.inval_cnt, 4'h0, s.cause};
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction : read_reg

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == exc_pkg::OFS_MST) || (a == exc_pkg::OFS_CSPC) ||
             (a == exc_pkg::OFS_CSST) || (a == exc_pkg::OFS_VPFX) ||
             (a == exc_pkg::OFS_SYND) || (a == exc_pkg::OFS_STAT);
  endfunction : mapped

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.pc_load = 1'b0;

    // write channel: address and data taken in either order
    if (axi_awvalid_in && cur_ff.aw_rdy) begin
      nxt_cur.awaddr = {axi_awaddr_in[7:2], 2'b00};
      nxt_cur.aw_rdy = 1'b0;
    end
    if (axi_wvalid_in && cur_ff.w_rdy) begin
      nxt_cur.wdata = axi_wdata_in;
      nxt_cur.wstrb = axi_wstrb_in;
      nxt_cur.w_rdy = 1'b0;
    end
    case (cur_ff.wr_state)
      exc_pkg::WR_IDLE: begin
        if (!cur_ff.aw_rdy && !cur_ff.w_rdy) begin
          nxt_cur.bvalid = 1'b1;
          nxt_cur.bresp = mapped(cur_ff.awaddr) ? exc_pkg::RESP_OKAY : exc_pkg::RESP_SLVERR;
          nxt_cur.wr_state = exc_pkg::WR_RESP;
          case (cur_ff.awaddr)
            exc_pkg::OFS_MST: begin
              // handler may reopen critical_allow once saves are done
              nxt_cur.mst = exc_pkg::merge(cur_ff.mst, cur_ff.wdata, cur_ff.wstrb);
            end
            exc_pkg::OFS_CSPC: begin
              nxt_cur.cspc = exc_pkg::merge(cur_ff.cspc, cur_ff.wdata, cur_ff.wstrb);
            end
            exc_pkg::OFS_CSST: begin
              nxt_cur.csst = exc_pkg::merge(cur_ff.csst, cur_ff.wdata, cur_ff.wstrb);
            end
            exc_pkg::OFS_VPFX: begin
              nxt_cur.vpfx = exc_pkg::merge(cur_ff.vpfx, cur_ff.wdata, cur_ff.wstrb) &
                             exc_pkg::VPFX_MASK;
            end
            exc_pkg::OFS_SYND: begin
              // software clearing the flag
              nxt_cur.synd = exc_pkg::merge(cur_ff.synd, cur_ff.wdata, cur_ff.wstrb) &
                             exc_pkg::SYND_MASK;
            end
            default: begin
              nxt_cur.bresp = nxt_cur.bresp;
            end
          endcase
        end
      end
      exc_pkg::WR_RESP: begin
        if (axi_bready_in) begin
          nxt_cur.bvalid = 1'b0;
          nxt_cur.aw_rdy = 1'b1;
          nxt_cur.w_rdy = 1'b1;
          nxt_cur.wr_state = exc_pkg::WR_IDLE;
        end
      end
      default: begin
        nxt_cur.wr_state = exc_pkg::WR_IDLE;
        nxt_cur.aw_rdy = 1'b1;
        nxt_cur.w_rdy = 1'b1;
        nxt_cur.bvalid = 1'b0;
      end
    endcase

    // read channel; data sampled from state before this cycle's updates
    case (cur_ff.rd_state)
      exc_pkg::RD_IDLE: begin
        if (axi_arvalid_in) begin
          nxt_cur.rdata = read_reg(cur_ff, {axi_araddr_in[7:2], 2'b00});
          nxt_cur.rresp = mapped({axi_araddr_in[7:2], 2'b00}) ? exc_pkg::RESP_OKAY :
                          exc_pkg::RESP_SLVERR;
          nxt_cur.rvalid = 1'b1;
          nxt_cur.ar_rdy = 1'b0;
          nxt_cur.rd_state = exc_pkg::RD_DATA;
        end
      end
      exc_pkg::RD_DATA: begin
        if (axi_rready_in) begin
          nxt_cur.rvalid = 1'b0;
          nxt_cur.ar_rdy = 1'b1;
          nxt_cur.rd_state = exc_pkg::RD_IDLE;
        end
      end
      default: begin
        nxt_cur.rd_state = exc_pkg::RD_IDLE;
        nxt_cur.ar_rdy = 1'b1;
        nxt_cur.rvalid = 1'b0;
      end
    endcase

    // hardware events come after the bus so that they win a same-cycle write
    if (fetch_fault) begin
      nxt_cur.synd[exc_pkg::SYND_FETCH_FAULT] = 1'b1;
    end

    if (inval_pulse) begin
      nxt_cur.inval_cnt = cur_ff.inval_cnt + 8'h01;
    end

    // all saves, state and redirect land in one registered update
    if (take_imc || take_dmc) begin
      nxt_cur.cspc = take_imc ? exec_pc_in : next_pc_in;
      nxt_cur.csst = cur_ff.mst;
      nxt_cur.mst = cur_ff.mst & ~exc_pkg::MC_CLR;
      nxt_cur.pc_target = exc_pkg::vec_addr(cur_ff.vpfx, exc_pkg::MC_VEC_OFS);
      nxt_cur.pc_load = 1'b1;
      nxt_cur.cause = take_imc ? exc_pkg::CAUSE_IMC : exc_pkg::CAUSE_DMC;
      if (take_imc) begin
        nxt_cur.synd = 32'h0000_0001;
      end
    end else if (take_crit || take_wdog) begin
      nxt_cur.cspc = next_pc_in;
      nxt_cur.csst = cur_ff.mst;
      nxt_cur.mst = cur_ff.mst & ~exc_pkg::CRIT_CLR;
      nxt_cur.pc_target = exc_pkg::vec_addr(cur_ff.vpfx,
        take_crit ? exc_pkg::CRIT_VEC_OFS : exc_pkg::WDOG_VEC_OFS);
      nxt_cur.pc_load = 1'b1;
      nxt_cur.cause = take_crit ? exc_pkg::CAUSE_CRIT : exc_pkg::CAUSE_WDOG;
    end else if (crit_return_in) begin
      // a return that collides with an entry is dropped; the core replays it
      nxt_cur.mst = cur_ff.csst;
      nxt_cur.pc_target = cur_ff.cspc;
      nxt_cur.pc_load = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cur_ff <= '{
        mst: exc_pkg::MST_RESET,
        cspc: 32'h0000_0000,
        csst: 32'h0000_0000,
        vpfx: exc_pkg::VPFX_RESET,
        synd: 32'h0000_0000,
        cause: 4'h0,
        inval_cnt: 8'h00,
        pc_load: 1'b0,
        pc_target: 32'h0000_0000,
        wr_state: exc_pkg::WR_IDLE,
        aw_rdy: 1'b1,
        w_rdy: 1'b1,
        awaddr: 8'h00,
        wdata: 32'h0000_0000,
        wstrb: 4'h0,
        bvalid: 1'b0,
        bresp: exc_pkg::RESP_OKAY,
        rd_state: exc_pkg::RD_IDLE,
        ar_rdy: 1'b1,
        rvalid: 1'b0,
        rdata: 32'h0000_0000,
        rresp: exc_pkg::RESP_OKAY
      };
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pc_load_out = cur_ff.pc_load;
  assign pc_target_out = cur_ff.pc_target;
  assign mst_out = cur_ff.mst;
  assign axi_awready_out = cur_ff.aw_rdy;
  assign axi_wready_out = cur_ff.w_rdy;
  assign axi_bvalid_out = cur_ff.bvalid;
  assign axi_bresp_out = cur_ff.bresp;
  assign axi_arready_out = cur_ff.ar_rdy;
  assign axi_rvalid_out = cur_ff.rvalid;
  assign axi_rdata_out = cur_ff.rdata;
  assign axi_rresp_out = cur_ff.rresp;

endmodule : crit_mc_entry

`default_nettype wire

// [bench/crit_mc_entry_assertions.sv]
/*
  concurrent checks on the ports of crit_mc_entry.
  assumes one clock and a synchronous active-high reset.
*/
`default_nettype none

module crit_mc_entry_checker #(
  parameter int FILL_WORDS = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // event inputs
  input wire logic crit_irq_in,
  input wire logic wdog_timeout_in,
  input wire logic precise_pending_in,
  input wire logic exec_valid_in,
  input wire logic exec_fetch_err_in,
  input wire logic data_bus_err_in,
  input wire logic crit_return_in,
  input wire logic fill_start_in,
  input wire logic fill_word_in,
  input wire logic fill_err_in,
  // outputs watched
  input wire logic pc_load_out,
  input wire logic [31:0] pc_target_out,
  input wire logic [31:0] mst_out,
  input wire logic line_validate_out,
  input wire logic line_invalidate_out,
  input wire logic axi_arvalid_in,
  input wire logic axi_arready_out,
  input wire logic axi_rvalid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic imc;
  logic any_ev;
  logic err_seen_ff;
  assign imc = exec_valid_in && exec_fetch_err_in;
  assign any_ev = crit_irq_in || wdog_timeout_in || imc || data_bus_err_in || crit_return_in;
  // remembers a bad word since the last fill start
  always_ff @(posedge clk_in) begin
    if (reset_in || fill_start_in) begin
      err_seen_ff <= 1'b0;
    end else if (fill_word_in && fill_err_in) begin
      err_seen_ff <= 1'b1;
    end
  end
  chk_crit_gate: assert property (
    crit_irq_in && !mst_out[exc_pkg::MST_CRIT] && !imc && !data_bus_err_in && !crit_return_in
    |=> !pc_load_out) else $error("critical input taken while disabled");
  chk_crit_vector: assert property (
    crit_irq_in && mst_out[exc_pkg::MST_CRIT] && !precise_pending_in && !imc && !data_bus_err_in
    |=> pc_load_out && pc_target_out[15:0] == 16'h0100
        && mst_out == ($past(mst_out) & ~exc_pkg::CRIT_CLR)) else $error("bad critical entry");
  chk_imc_vector: assert property (
    imc && mst_out[exc_pkg::MST_MCE] |=> pc_load_out && pc_target_out[15:0] == 16'h0200
      && (mst_out & exc_pkg::MC_CLR) == 32'h0) else $error("bad fetch check entry");
  chk_dmc_vector: assert property (
    data_bus_err_in && mst_out[exc_pkg::MST_MCE] && !imc |=> pc_load_out
      && pc_target_out[15:0] == 16'h0200 && mst_out == ($past(mst_out) & ~exc_pkg::MC_CLR))
    else $error("bad data check entry");
  chk_imc_masked: assert property (
    imc && !mst_out[exc_pkg::MST_MCE] && !mst_out[exc_pkg::MST_CRIT] && !crit_return_in
    |=> !pc_load_out) else $error("disabled fetch check redirected");
  chk_no_cause: assert property (!any_ev |=> !pc_load_out)
    else $error("redirect without a cause");
  chk_return_load: assert property (
    crit_return_in && !imc && !data_bus_err_in && !crit_irq_in && !wdog_timeout_in
    |=> pc_load_out) else $error("return did not redirect");
  chk_target_hold: assert property (!pc_load_out |-> $stable(pc_target_out))
    else $error("target moved without a load");
  chk_fill_clean: assert property (line_validate_out |-> !err_seen_ff && !line_invalidate_out)
    else $error("errored line validated");
  chk_fill_bad: assert property (line_invalidate_out |-> err_seen_ff)
    else $error("clean line invalidated");
  chk_read_answer: assert property (axi_arvalid_in && axi_arready_out |=> axi_rvalid_out)
    else $error("read answer late");
  cov_crit: cover property (pc_load_out && pc_target_out[15:0] == 16'h0100);
  cov_mc: cover property (pc_load_out && pc_target_out[15:0] == 16'h0200);
  cov_inval: cover property (line_invalidate_out);
endmodule : crit_mc_entry_checker

bind crit_mc_entry crit_mc_entry_checker #(.FILL_WORDS(FILL_WORDS)) i_crit_mc_entry_checker (.*);

`default_nettype wire

// [bench/line_fill_source.sv]
/*
  far-side fill path model: start pulse, then one word per pulse.
  assumes one fill at a time.
*/
`default_nettype none

module line_fill_source #(
  parameter int WORDS = 8
) (
  // clock
  input wire logic clk_in,
  // fill stream
  output logic fill_start_out,
  output logic fill_word_out,
  output logic fill_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fill_start_out = 1'b0;
    fill_word_out = 1'b0;
    fill_err_out = 1'b0;
  end
  // err_idx out of range gives a clean line; gap stalls between words
  task automatic run_fill(input int err_idx, input int gap);
    @(posedge clk_in);
    fill_start_out <= 1'b1;
    @(posedge clk_in);
    fill_start_out <= 1'b0;
    for (int i = 0; i < WORDS; i++) begin
      repeat (gap) begin
        fill_word_out <= 1'b0;
        // error flag means nothing between words, so it wanders
        fill_err_out <= ~fill_err_out;
        @(posedge clk_in);
      end
      fill_word_out <= 1'b1;
      fill_err_out <= (i == err_idx);
      @(posedge clk_in);
    end
    fill_word_out <= 1'b0;
    fill_err_out <= ~fill_err_out;
    repeat (2) @(posedge clk_in);
  endtask : run_fill
endmodule : line_fill_source

`default_nettype wire

// [bench/test_crit_mc_entry.sv]
/*
  self-checking bench for crit_mc_entry: register tasks, events and fills.
  assumes exc_pkg is compiled first.
*/
`default_nettype none

module test_crit_mc_entry;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WORDS = exc_pkg::FILL_WORDS;
  localparam logic [6:0] CRIT = 7'h40, WDOG = 7'h20, PREC = 7'h10, EXV = 7'h08;
  localparam logic [6:0] EXERR = 7'h04, DERR = 7'h02, RET = 7'h01;
  localparam logic [31:0] NPC = 32'h0000_2468;
  localparam logic [31:0] XPC = 32'h0000_1354;
  localparam logic [31:0] FULL = exc_pkg::MC_CLR | 32'h0000_0001;
  localparam logic [31:0] VP = 32'habcd_0000;
  logic clk_in, reset_in, fill_start, fill_word, fill_err;
  logic pc_load_out, line_validate_out, line_invalidate_out;
  logic [6:0] ev;
  logic [31:0] pc_target_out, mst_out, wdata, rdata;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int errors, checks_done, cycles, n_val, n_inv;

  crit_mc_entry #(.FILL_WORDS(WORDS)) i_crit_mc_entry (
    .clk_in(clk_in), .reset_in(reset_in), .crit_irq_in(ev[6]), .wdog_timeout_in(ev[5]),
    .precise_pending_in(ev[4]), .next_pc_in(NPC), .exec_valid_in(ev[3]), .exec_pc_in(XPC),
    .exec_fetch_err_in(ev[2]), .data_bus_err_in(ev[1]), .crit_return_in(ev[0]),
    .fill_start_in(fill_start), .fill_word_in(fill_word), .fill_err_in(fill_err),
    .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .mst_out(mst_out),
    .line_validate_out(line_validate_out), .line_invalidate_out(line_invalidate_out),
    .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
    .axi_wdata_in(wdata), .axi_wstrb_in(4'hf), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
    .axi_bready_in(bready), .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
    .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready));
  line_fill_source #(.WORDS(WORDS)) i_line_fill_source (.clk_in(clk_in),
    .fill_start_out(fill_start), .fill_word_out(fill_word), .fill_err_out(fill_err));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task close_out();
    $display("comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // about 150 cycles needed
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      close_out();
    end
  end
  always @(negedge clk_in) begin
    if (line_validate_out === 1'b1) n_val++;
    if (line_invalidate_out === 1'b1) n_inv++;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk
  // values read right after an edge are those sampled at it
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk_in);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("write response", 32'h0, {30'h0, bresp});
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk_in);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(what, exp, d);
  endtask : rd_chk
  // raise a set of one-cycle events, then look at the redirect a cycle later
  task fire(input logic [6:0] s, input logic exp_ld, input logic [31:0] exp_tgt);
    @(posedge clk_in);
    ev <= s;
    @(posedge clk_in);
    ev <= 7'h00;
    @(negedge clk_in);
    chk("pc_load", {31'h0, exp_ld}, {31'h0, pc_load_out});
    if (exp_ld) chk("pc_target", exp_tgt, pc_target_out);
  endtask : fire

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    reset_in = 1'b1;
    ev = 7'h00;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    chk("state after reset", exc_pkg::MST_RESET, mst_out);
    wr(exc_pkg::OFS_VPFX, 32'habcd_1234);
    rd_chk("vector prefix", exc_pkg::OFS_VPFX, VP);
    rd(8'h18, d, r);
    chk("unmapped response", {30'h0, exc_pkg::RESP_SLVERR}, {30'h0, r});
    wr(exc_pkg::OFS_MST, FULL);
    fire(CRIT | PREC, 1'b0, 32'h0);
    fire(CRIT, 1'b1, VP | 32'h0100);
    chk("state critical entry", FULL & ~exc_pkg::CRIT_CLR, mst_out);
    rd_chk("crit_save_pc", exc_pkg::OFS_CSPC, NPC);
    rd_chk("crit_save_state", exc_pkg::OFS_CSST, FULL);
    fire(CRIT, 1'b0, 32'h0);
    fire(WDOG, 1'b0, 32'h0);
    fire(RET, 1'b1, NPC);
    chk("state restored", FULL, mst_out);
    fire(WDOG, 1'b1, VP | 32'h1020);
    fire(RET, 1'b1, NPC);
    fire(EXV, 1'b0, 32'h0);
    wr(exc_pkg::OFS_SYND, 32'h0000_0370);
    fire(EXV | EXERR | CRIT, 1'b1, VP | 32'h0200);
    chk("state fetch check", FULL & ~exc_pkg::MC_CLR, mst_out);
    rd_chk("crit_save_pc", exc_pkg::OFS_CSPC, XPC);
    rd_chk("crit_save_state", exc_pkg::OFS_CSST, FULL);
    rd_chk("syndrome", exc_pkg::OFS_SYND, 32'h1);
    fire(RET, 1'b1, XPC);
    wr(exc_pkg::OFS_SYND, 32'h0);
    fire(DERR, 1'b1, VP | 32'h0200);
    chk("state data check", FULL & ~exc_pkg::MC_CLR, mst_out);
    rd_chk("crit_save_pc", exc_pkg::OFS_CSPC, NPC);
    fire(EXV | EXERR, 1'b0, 32'h0);
    rd_chk("syndrome", exc_pkg::OFS_SYND, 32'h1);
    fire(DERR, 1'b0, 32'h0);
    wr(exc_pkg::OFS_MST, FULL);
    repeat (4) begin
      @(negedge clk_in);
      chk("pc_load idle", 32'h0, {31'h0, pc_load_out});
    end
    i_line_fill_source.run_fill(WORDS, 0);
    i_line_fill_source.run_fill(3, 2);
    i_line_fill_source.run_fill(WORDS - 1, 0);
    chk("validated lines", 32'h1, 32'(n_val));
    chk("invalidated lines", 32'h2, 32'(n_inv));
    rd(exc_pkg::OFS_STAT, d, r);
    chk("invalidated count", 32'h2, {24'h0, d[15:8]});
    close_out();
  end
endmodule : test_crit_mc_entry

`default_nettype wire
